/* verilog/scp_pkg.sv */
// package for the six-channel pwm core: register addresses, field
// positions, reset values and output mode codes.
// assumes an 8-bit register port with byte-wide data.
package scp_pkg;
    // =========================================================
    // register addresses
    localparam logic [7:0] ADR_ALT_ROUTE = 8'hc6;
    localparam logic [7:0] ADR_PRIM_ROUTE = 8'hde;
    localparam logic [7:0] ADR_WAVE_CTRL2 = 8'hdf;
    localparam logic [7:0] ADR_DT_ENABLE = 8'hf9;
    localparam logic [7:0] ADR_DT_LOW = 8'hfa;
    localparam logic [7:0] ADR_PERIOD_LO = 8'hd9;
    localparam logic [7:0] ADR_PERIOD_HI = 8'hd1;
    localparam logic [7:0] ADR_CNT_LO = 8'he1;
    localparam logic [7:0] ADR_CNT_HI = 8'he2;
    // duty byte addresses, channel 5 leftmost
    localparam logic [5:0][7:0] ADR_DUTY_LO =
        {8'hcd, 8'hcc, 8'hdd, 8'hdc, 8'hdb, 8'hda};
    localparam logic [5:0][7:0] ADR_DUTY_HI =
        {8'hc5, 8'hc4, 8'hd5, 8'hd4, 8'hd3, 8'hd2};
    // =========================================================
    // field positions and writable masks
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_TYPE_BIT = 4;
    localparam int CTL_DIV_HI = 2;
    localparam int DT_MSB_BIT = 4;
    localparam logic [7:0] PRIM_ROUTE_MASK = 8'h3f;
    localparam logic [7:0] ALT_ROUTE_MASK = 8'h2e;
    localparam logic [7:0] DT_ENABLE_MASK = 8'h17;
    // =========================================================
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // =========================================================
    // output mode codes
    typedef enum logic [1:0] {
        SCP_MODE_INDEP = 2'b00,
        SCP_MODE_COMP = 2'b01,
        SCP_MODE_SYNC = 2'b10,
        SCP_MODE_RSVD = 2'b11
    } scp_mode_t;
endpackage

/* verilog/scp_pwm_core.sv */
// six-channel, three-pair pwm generator with dead-time insertion and
// pin routing between port i/o and pwm outputs.
// assumes a same-clock register port and a same-clock write permit
// from the timed-access guard; pins are resolved outside.
module scp_pwm_core (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // timed-access guard
    input wire logic timed_access_guard_in,
    // port i/o side of the shared pins
    input wire logic [5:0] prim_port_data_in,
    input wire logic [5:0] prim_port_oe_n_in,
    input wire logic [5:0] alt_port_data_in,
    input wire logic [5:0] alt_port_oe_n_in,
    // pins and channel outputs
    output logic [5:0] prim_pin_out,
    output logic [5:0] prim_pin_oe_n_out,
    output logic [5:0] alt_pin_out,
    output logic [5:0] alt_pin_oe_n_out,
    output logic [5:0] pwm_ch_out
);
    import scp_pkg::*;

    // =========================================================
    // register file
    logic [7:0] alt_pin_route_select;
    logic [7:0] primary_pin_route_select;
    logic [7:0] waveform_control_two;
    logic [7:0] deadtime_pair_enable;
    logic [7:0] deadtime_count_low;
    logic [15:0] period;
    logic [15:0] duty [6];
    logic [15:0] cnt;
    logic cnt_down;

    // finds which duty byte an address names; bit 4 flags a hit and
    // bit 3 picks the high byte
    function automatic logic [4:0] duty_decode(input logic [7:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 6; i++) begin
            if (a == ADR_DUTY_LO[i]) begin
                r = {2'b10, i[2:0]};
            end
            if (a == ADR_DUTY_HI[i]) begin
                r = {2'b11, i[2:0]};
            end
        end
        return r;
    endfunction

    logic [4:0] wr_dec;
    logic [4:0] rd_dec;
    logic dt_wr_ok;
    assign wr_dec = duty_decode(reg_addr_in);
    assign rd_dec = wr_dec;
    assign dt_wr_ok = reg_wr_in && timed_access_guard_in;

    // control and routing registers
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            alt_pin_route_select <= REG_RESET;
            primary_pin_route_select <= REG_RESET;
            waveform_control_two <= REG_RESET;
            period <= WORD_RESET;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                ADR_ALT_ROUTE: begin
                    alt_pin_route_select <= reg_wdata_in & ALT_ROUTE_MASK;
                end
                ADR_PRIM_ROUTE: begin
                    primary_pin_route_select <=
                        reg_wdata_in & PRIM_ROUTE_MASK;
                end
                ADR_WAVE_CTRL2: waveform_control_two <= reg_wdata_in;
                ADR_PERIOD_LO: period[7:0] <= reg_wdata_in;
                ADR_PERIOD_HI: period[15:8] <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            deadtime_pair_enable <= REG_RESET;
            deadtime_count_low <= REG_RESET;
        end else if (dt_wr_ok && reg_addr_in == ADR_DT_ENABLE) begin
            deadtime_pair_enable <= reg_wdata_in & DT_ENABLE_MASK;
        end else if (dt_wr_ok && reg_addr_in == ADR_DT_LOW) begin
            deadtime_count_low <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 6; i++) begin
                duty[i] <= WORD_RESET;
            end
        end else if (reg_wr_in && wr_dec[4]) begin
            if (wr_dec[3]) begin
                duty[wr_dec[2:0]][15:8] <= reg_wdata_in;
            end else begin
                duty[wr_dec[2:0]][7:0] <= reg_wdata_in;
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= REG_RESET;
        end else if (reg_rd_in) begin
            if (rd_dec[4]) begin
                reg_rdata_out <= rd_dec[3] ? duty[rd_dec[2:0]][15:8]
                                           : duty[rd_dec[2:0]][7:0];
            end else begin
                unique case (reg_addr_in)
                    ADR_ALT_ROUTE: reg_rdata_out <= alt_pin_route_select;
                    ADR_PRIM_ROUTE: begin
                        reg_rdata_out <= primary_pin_route_select;
                    end
                    ADR_WAVE_CTRL2: reg_rdata_out <= waveform_control_two;
                    ADR_DT_ENABLE: reg_rdata_out <= deadtime_pair_enable;
                    ADR_DT_LOW: reg_rdata_out <= deadtime_count_low;
                    ADR_PERIOD_LO: reg_rdata_out <= period[7:0];
                    ADR_PERIOD_HI: reg_rdata_out <= period[15:8];
                    ADR_CNT_LO: reg_rdata_out <= cnt[7:0];
                    ADR_CNT_HI: reg_rdata_out <= cnt[15:8];
                    default: reg_rdata_out <= REG_RESET;
                endcase
            end
        end
    end

    // =========================================================
    // field decode
    scp_mode_t output_mode_select;
    logic count_type_select;
    logic [2:0] clock_prescale_select;
    logic [8:0] deadtime_count_value;
    assign output_mode_select =
        scp_mode_t'(waveform_control_two[CTL_MODE_HI:CTL_MODE_LO]);
    assign count_type_select = waveform_control_two[CTL_TYPE_BIT];
    assign clock_prescale_select = waveform_control_two[CTL_DIV_HI:0];
    assign deadtime_count_value =
        {deadtime_pair_enable[DT_MSB_BIT], deadtime_count_low};

    // =========================================================
    // pwm clock prescaler: one tick every 2^n system clocks
    logic [6:0] presc;
    logic [6:0] presc_mask;
    logic tick;
    assign presc_mask = 7'((8'h01 << clock_prescale_select) - 8'h01);
    assign tick = (presc & presc_mask) == presc_mask;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            presc <= 7'h00;
        end else begin
            presc <= presc + 7'h01;
        end
    end

    // =========================================================
    // shared 16-bit counter
    // edge wrap after period, period plus one steps
    // center dual slope, twice period steps
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cnt <= WORD_RESET;
            cnt_down <= 1'b0;
        end else if (tick) begin
            if (!count_type_select) begin
                cnt_down <= 1'b0;
                cnt <= (cnt >= period) ? WORD_RESET : cnt + 16'h0001;
            end else if (cnt_down) begin
                // a period shrunk below the count ends up here too
                cnt <= (cnt == WORD_RESET) ? WORD_RESET : cnt - 16'h0001;
                cnt_down <= (cnt > 16'h0001);
            end else if (cnt >= period) begin
                cnt_down <= (period != WORD_RESET);
                cnt <= (period != WORD_RESET) ? cnt - 16'h0001
                                             : WORD_RESET;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // =========================================================
    // raw channel generators
    logic [5:0] raw_channel_signal;
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gen_raw
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    raw_channel_signal[g] <= 1'b0;
                end else if (tick && !count_type_select) begin
                    // clear on match beats set at zero
                    if (cnt == duty[g]) begin
                        raw_channel_signal[g] <= 1'b0;
                    end else if (cnt == WORD_RESET) begin
                        raw_channel_signal[g] <= 1'b1;
                    end
                end else if (tick && cnt == duty[g]) begin
                    raw_channel_signal[g] <= cnt_down;
                end
            end
        end
    endgenerate

    // =========================================================
    // mode selection and dead time per pair
    logic [2:0] dt_on;
    logic [5:0] tgt;
    logic [2:0] dt_busy;
    logic [8:0] dt_cnt [3];
    generate
        for (g = 0; g < 3; g++) begin : gen_pair
            assign dt_on[g] = deadtime_pair_enable[g] &&
                              output_mode_select == SCP_MODE_COMP;
            always_comb begin
                tgt[2*g] = raw_channel_signal[2*g];
                unique case (output_mode_select)
                    SCP_MODE_COMP: tgt[2*g+1] = !raw_channel_signal[2*g];
                    SCP_MODE_SYNC: tgt[2*g+1] = raw_channel_signal[2*g];
                    // reserved code falls back to independent
                    default: tgt[2*g+1] = raw_channel_signal[2*g+1];
                endcase
            end
            // falls pass at once, rises wait for the count to reach zero
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    pwm_ch_out[2*g+1 -: 2] <= 2'b00;
                    dt_busy[g] <= 1'b0;
                    dt_cnt[g] <= 9'h000;
                end else if (!dt_on[g]) begin
                    pwm_ch_out[2*g+1 -: 2] <= tgt[2*g+1 -: 2];
                    dt_busy[g] <= 1'b0;
                end else if ((tgt[2*g+1 -: 2] &
                              ~pwm_ch_out[2*g+1 -: 2]) == 2'b00) begin
                    pwm_ch_out[2*g+1 -: 2] <= tgt[2*g+1 -: 2];
                    dt_busy[g] <= 1'b0;
                end else begin
                    pwm_ch_out[2*g+1 -: 2] <=
                        pwm_ch_out[2*g+1 -: 2] & tgt[2*g+1 -: 2];
                    if (!dt_busy[g]) begin
                        // load value, plus one cycle to release
                        dt_busy[g] <= 1'b1;
                        dt_cnt[g] <= deadtime_count_value;
                    end else if (dt_cnt[g] == 9'h000) begin
                        pwm_ch_out[2*g+1 -: 2] <= tgt[2*g+1 -: 2];
                        dt_busy[g] <= 1'b0;
                    end else begin
                        dt_cnt[g] <= dt_cnt[g] - 9'h001;
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // pin routing, registered so pins change on a clean edge
    // route bits choose pwm or port
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prim_pin_out <= 6'h00;
            prim_pin_oe_n_out <= 6'h3f;
            alt_pin_out <= 6'h00;
            alt_pin_oe_n_out <= 6'h3f;
        end else begin
            for (int i = 0; i < 6; i++) begin
                prim_pin_out[i] <= primary_pin_route_select[i] ?
                    pwm_ch_out[i] : prim_port_data_in[i];
                prim_pin_oe_n_out[i] <= primary_pin_route_select[i] ?
                    1'b0 : prim_port_oe_n_in[i];
                alt_pin_out[i] <= alt_pin_route_select[i] ?
                    pwm_ch_out[i] : alt_port_data_in[i];
                alt_pin_oe_n_out[i] <= alt_pin_route_select[i] ?
                    1'b0 : alt_port_oe_n_in[i];
            end
        end
    end

    // =========================================================
    // checks
    logic [9:0] hold0;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            hold0 <= 10'h000;
        end else if (tgt[0] && !pwm_ch_out[0]) begin
            hold0 <= hold0 + 10'h001;
        end else begin
            hold0 <= 10'h000;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_edge_wrap: assert property (
        tick && !count_type_select && cnt >= period |=> cnt == 16'h0000)
        else $error("edge counter did not wrap");
    a_center_turn: assert property (
        tick && count_type_select && !cnt_down && cnt == period &&
        period > 16'h0001 |=> cnt_down && cnt == $past(period) - 16'h0001)
        else $error("center counter did not turn down");
    a_edge_set: assert property (
        tick && !count_type_select && cnt == 16'h0000 &&
        duty[0] != 16'h0000 |=> raw_channel_signal[0])
        else $error("edge raw not set at zero");
    a_center_clear: assert property (
        tick && count_type_select && !cnt_down && cnt == duty[0]
        |=> !raw_channel_signal[0])
        else $error("center up match did not clear");
    a_indep_pass: assert property (
        output_mode_select == SCP_MODE_INDEP ##1
        output_mode_select == SCP_MODE_INDEP
        |-> pwm_ch_out[0] == $past(raw_channel_signal[0]))
        else $error("independent channel not passed");
    a_comp_inverse: assert property (
        output_mode_select == SCP_MODE_COMP && !dt_on[0] ##1
        output_mode_select == SCP_MODE_COMP && !dt_on[0]
        |-> pwm_ch_out[1] == !$past(raw_channel_signal[0]))
        else $error("complementary channel not inverted");
    a_sync_copy: assert property (
        output_mode_select == SCP_MODE_SYNC ##1
        output_mode_select == SCP_MODE_SYNC
        |-> pwm_ch_out[1] == $past(raw_channel_signal[0]))
        else $error("synchronized channel not copied");
    a_dt_delay: assert property (
        dt_on[0] && $past(dt_on[0]) &&
        $stable(deadtime_count_value) && $rose(pwm_ch_out[0])
        |-> $past(hold0) == 10'(deadtime_count_value) + 10'h001)
        else $error("dead time length wrong");
    a_ta_reject: assert property (
        reg_wr_in && !timed_access_guard_in && reg_addr_in == ADR_DT_LOW
        |=> $stable(deadtime_count_low))
        else $error("unguarded dead-time write took effect");
    a_prim_route: assert property (
        primary_pin_route_select[2]
        |=> prim_pin_out[2] == $past(pwm_ch_out[2]) &&
            !prim_pin_oe_n_out[2])
        else $error("primary pin not routed to pwm");
    a_alt_port: assert property (
        !alt_pin_route_select[3]
        |=> alt_pin_out[3] == $past(alt_port_data_in[3]))
        else $error("alternate pin not left to port");
endmodule

/* testbench/scp_bridge_model.sv */
// half-bridge power stage model for the three channel pairs.
// assumes even channels drive upper switches, odd ones lower switches.
module scp_bridge_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // gate drive from the pwm core
    input wire logic [5:0] gate_in,
    // cycles with a shorted leg
    output logic [15:0] overlap_cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // shoot-through watch
    // both switches of one leg on shorts the supply, so count it
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            overlap_cnt_out <= 16'h0000;
        end else if ((gate_in[0] & gate_in[1]) | (gate_in[2] & gate_in[3])
                | (gate_in[4] & gate_in[5])) begin
            overlap_cnt_out <= overlap_cnt_out + 16'h0001;
        end
    end
endmodule

/* testbench/testbench.sv */
// self-checking bench for the six-channel pwm core.
// assumes the core's register port and a half-bridge load model.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import scp_pkg::*;
    // =========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic guard = 1'b0;
    logic [5:0] pdata = 6'h2a;
    logic [5:0] poe = 6'h15;
    logic [5:0] adata = 6'h15;
    logic [5:0] aoe = 6'h2a;
    logic [7:0] rdata;
    logic [5:0] ppin, ppoe, apin, apoe, pwm, prevp;
    logic [5:0] eprim = 6'h00;
    logic [5:0] ealt = 6'h00;
    logic [15:0] ovl, ovl0;
    logic [7:0] modes [3] = '{8'h40, 8'h80, 8'hc0};
    int same_exp [3] = '{0, 20, 12};
    int hi1_exp [3] = '{12, 8, 0};
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int hi [6];
    int rise [6];
    int same01, pinbad;
    scp_pwm_core u_scp_pwm_core (.ref_clk_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .timed_access_guard_in(guard), .prim_port_data_in(pdata),
        .prim_port_oe_n_in(poe), .alt_port_data_in(adata),
        .alt_port_oe_n_in(aoe), .prim_pin_out(ppin),
        .prim_pin_oe_n_out(ppoe), .alt_pin_out(apin),
        .alt_pin_oe_n_out(apoe), .pwm_ch_out(pwm));
    scp_bridge_model u_scp_bridge_model (.ref_clk_in(clk),
        .rst_n_in(rst_n), .gate_in(pwm), .overlap_cnt_out(ovl));
    // =========================================================
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // =========================================================
    // tasks
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle write; guard only qualifies the protected registers
    task automatic wreg(input logic [7:0] a, input logic [7:0] v,
            input logic g);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        guard <= g;
        @(posedge clk);
        wr <= 1'b0;
        guard <= 1'b0;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic setw(input logic [7:0] ah, input logic [7:0] al,
            input logic [15:0] v);
        wreg(al, v[7:0], 1'b0);
        wreg(ah, v[15:8], 1'b0);
    endtask
    // sample n cycles: high and rising counts, pair match, pin routing
    task automatic win(input int n);
        logic [5:0] ep;
        for (int c = 0; c < 6; c++) begin
            hi[c] = 0;
            rise[c] = 0;
        end
        same01 = 0;
        pinbad = 0;
        @(posedge clk);
        #1;
        prevp = pwm;
        repeat (n) begin
            @(posedge clk);
            #1;
            for (int c = 0; c < 6; c++) begin
                if (pwm[c] === 1'b1) hi[c]++;
                if (pwm[c] === 1'b1 && prevp[c] === 1'b0) rise[c]++;
            end
            if (pwm[1] === pwm[0]) same01++;
            ep = (eprim & prevp) | (~eprim & pdata);
            if (ppin !== ep || ppoe !== (poe & ~eprim)) pinbad++;
            ep = (ealt & prevp) | (~ealt & adata);
            if (apin !== ep || apoe !== (aoe & ~ealt)) pinbad++;
            prevp = pwm;
        end
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, duty bytes and an unmapped place
        chkr(ADR_PRIM_ROUTE, 8'h00);
        chkr(ADR_ALT_ROUTE, 8'h00);
        chkr(ADR_WAVE_CTRL2, 8'h00);
        chkr(ADR_DT_ENABLE, 8'h00);
        chkr(ADR_DT_LOW, 8'h00);
        for (int c = 0; c < 6; c++) begin
            chkr(ADR_DUTY_LO[c], 8'h00);
            chkr(ADR_DUTY_HI[c], 8'h00);
        end
        chkr(8'h80, 8'h00);
        // period zero after reset keeps the counter parked at zero
        chkr(ADR_CNT_LO, 8'h00);
        chkr(ADR_CNT_HI, 8'h00);
        $display("test reset values done");
        // writable bits and write protection
        wreg(ADR_PRIM_ROUTE, 8'hff, 1'b0);
        chkr(ADR_PRIM_ROUTE, 8'h3f);
        wreg(ADR_ALT_ROUTE, 8'hff, 1'b0);
        chkr(ADR_ALT_ROUTE, 8'h2e);
        wreg(ADR_DT_ENABLE, 8'hff, 1'b0);
        chkr(ADR_DT_ENABLE, 8'h00);
        wreg(ADR_DT_ENABLE, 8'hff, 1'b1);
        chkr(ADR_DT_ENABLE, 8'h17);
        wreg(ADR_DT_LOW, 8'h5a, 1'b0);
        chkr(ADR_DT_LOW, 8'h00);
        wreg(ADR_DT_LOW, 8'h5a, 1'b1);
        chkr(ADR_DT_LOW, 8'h5a);
        wreg(ADR_DUTY_HI[5], 8'hcc, 1'b0);
        chkr(ADR_DUTY_HI[5], 8'hcc);
        wreg(ADR_DUTY_HI[5], 8'h00, 1'b0);
        wreg(ADR_DT_ENABLE, 8'h00, 1'b1);
        wreg(ADR_PRIM_ROUTE, 8'h05, 1'b0);
        wreg(ADR_ALT_ROUTE, 8'h04, 1'b0);
        eprim = 6'h05;
        ealt = 6'h04;
        $display("test register access done");
        // edge type, period 4: five-cycle frame, duty 2 high
        setw(ADR_PERIOD_HI, ADR_PERIOD_LO, 16'h0004);
        setw(ADR_DUTY_HI[0], ADR_DUTY_LO[0], 16'h0002);
        setw(ADR_DUTY_HI[2], ADR_DUTY_LO[2], 16'hffff);
        repeat (10) @(posedge clk);
        win(20);
        chk(hi[0], 8);
        chk(rise[0], 4);
        chk(hi[2], 20);
        chk(hi[1], 0);
        chk(pinbad, 0);
        // complementary, synchronized and reserved codes
        for (int k = 0; k < 3; k++) begin
            wreg(ADR_WAVE_CTRL2, modes[k], 1'b0);
            repeat (5) @(posedge clk);
            win(20);
            chk(same01, same_exp[k]);
            chk(hi[1], hi1_exp[k]);
        end
        $display("test edge type and modes done");
        // prescale by two stretches the frame to ten cycles
        wreg(ADR_WAVE_CTRL2, 8'h01, 1'b0);
        repeat (30) @(posedge clk);
        win(100);
        chk(hi[0], 40);
        chk(rise[0], 10);
        // center type, period 4: eight-cycle frame, half high
        wreg(ADR_WAVE_CTRL2, 8'h10, 1'b0);
        repeat (20) @(posedge clk);
        win(80);
        chk(hi[0], 40);
        chk(rise[0], 10);
        chk(pinbad, 0);
        $display("test prescale and center type done");
        // dead time 2 on pair 0: each rise comes three cycles late
        wreg(ADR_WAVE_CTRL2, 8'h40, 1'b0);
        setw(ADR_PERIOD_HI, ADR_PERIOD_LO, 16'h0009);
        setw(ADR_DUTY_HI[0], ADR_DUTY_LO[0], 16'h0005);
        setw(ADR_DUTY_HI[2], ADR_DUTY_LO[2], 16'h0005);
        // count changed only while dead time is still off
        wreg(ADR_DT_LOW, 8'h02, 1'b1);
        wreg(ADR_DT_ENABLE, 8'h01, 1'b1);
        repeat (30) @(posedge clk);
        ovl0 = ovl;
        win(20);
        chk(hi[0], 4);
        chk(hi[1], 4);
        chk(hi[2], 10);
        chk(hi[3], 10);
        chk(ovl - ovl0, 0);
        wreg(ADR_WAVE_CTRL2, 8'h00, 1'b0);
        repeat (20) @(posedge clk);
        win(20);
        chk(hi[0], 10);
        // top count bit: 256 gives a 257-cycle hold-off
        setw(ADR_PERIOD_HI, ADR_PERIOD_LO, 16'h0257);
        setw(ADR_DUTY_HI[0], ADR_DUTY_LO[0], 16'h012c);
        // independent mode keeps dead time off while the count moves
        wreg(ADR_DT_LOW, 8'h00, 1'b1);
        wreg(ADR_DT_ENABLE, 8'h11, 1'b1);
        wreg(ADR_WAVE_CTRL2, 8'h40, 1'b0);
        repeat (1200) @(posedge clk);
        ovl0 = ovl;
        win(600);
        chk(hi[0], 43);
        chk(hi[1], 43);
        chk(ovl - ovl0, 0);
        $display("test dead time done");
        tally_and_finish();
    end
endmodule
